// [hw/acti_device_end.sv]
// converter end: conversion timer, output/input shift registers, strobe
`timescale 1ns/1ps
module acti_device_end #(
    parameter int LANES = 1
) (
    input  logic                              clock,
    input  logic                              sys_rst,
    acti_link_if.device                       link,
    input  logic [acti_pkg::READ_BITS-1:0]    sample_data,
    input  acti_pkg::acti_out_mode_type       output_protocol_select,
    input  logic [1:0]                        strobe_source_select,
    input  logic                              ddr_enable,
    output logic                              sample_taken,
    output logic [acti_pkg::WORD_BITS-1:0]    cmd_word,
    output logic                              cmd_valid
);
    localparam int W      = acti_pkg::WORD_BITS;
    localparam int GROUPS = (W + LANES - 1) / LANES;
    localparam logic [3:0] PIN_IDLE = 4'h4;

    logic [3:0]                   pin_s1_reg;
    logic [3:0]                   pin_s2_reg;
    logic [3:0]                   pin_d_reg;
    logic                         start_rise;
    logic                         cs_fall;
    logic                         cs_rise;
    logic                         sclk_rise;
    logic                         sclk_fall;
    logic                         busy_reg;
    logic [acti_pkg::CNT_W-1:0]   conv_cnt_reg;
    logic [acti_pkg::READ_BITS-1:0] sample_reg;
    logic [W-1:0]                 out_word_reg;
    logic                         frame_reg;
    logic                         zone2_reg;
    logic [W-1:0]                 odr_reg;
    logic [W-1:0]                 idr_reg;
    logic [5:0]                   shift_cnt_reg;
    logic [5:0]                   sclk_cnt_reg;
    logic [acti_pkg::CNT_W-1:0]   int_cnt_reg;
    logic                         int_clk_reg;
    logic                         int_toggle;
    logic                         int_rise;
    logic                         int_fall;
    logic                         echo_reg;
    logic                         devclk;
    logic                         use_int;
    logic                         launch;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; only the second stage and its delayed copy are read

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_s1_reg <= PIN_IDLE;
            pin_s2_reg <= PIN_IDLE;
            pin_d_reg  <= PIN_IDLE;
        end else begin
            pin_s1_reg <= {link.conversion_start, link.cs_n, link.sclk,
                           link.sdi};
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg  <= pin_s2_reg;
        end
    end

    assign start_rise = pin_s2_reg[3] & ~pin_d_reg[3];
    assign cs_fall    = ~pin_s2_reg[2] & pin_d_reg[2];
    assign cs_rise    = pin_s2_reg[2] & ~pin_d_reg[2];
    assign sclk_rise  = pin_s2_reg[1] & ~pin_d_reg[1];
    assign sclk_fall  = ~pin_s2_reg[1] & pin_d_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // conversion timer

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            busy_reg     <= 1'b0;
            conv_cnt_reg <= '0;
            sample_reg   <= '0;
            out_word_reg <= '0;
            sample_taken <= 1'b0;
        end else begin
            sample_taken <= start_rise;
            if (start_rise) begin
                busy_reg     <= 1'b1;
                conv_cnt_reg <= acti_pkg::CNT_W'(acti_pkg::CONV_CYC - 1);
                sample_reg   <= sample_data;
            end else if (busy_reg) begin
                if (conv_cnt_reg == '0) begin
                    // result becomes available; frames in flight are untouched
                    busy_reg     <= 1'b0;
                    out_word_reg <= {sample_reg, {acti_pkg::PAD_BITS{1'b0}}};
                end else begin
                    conv_cnt_reg <= conv_cnt_reg - 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // launch clock selection

    assign devclk  = output_protocol_select == acti_pkg::OUT_DEVCLK;
    // in zone 2 the internal source is refused; the strobe echoes sclk
    assign use_int = devclk & ~zone2_reg &
                     (strobe_source_select != acti_pkg::STROBE_ECHO);

    always_ff @(posedge clock) begin
        if (sys_rst || !frame_reg || !use_int) begin
            int_cnt_reg <= '0;
            int_clk_reg <= 1'b0;
        end else if (shift_cnt_reg < 6'(GROUPS)) begin
            if (int_toggle) begin
                int_cnt_reg <= '0;
                int_clk_reg <= ~int_clk_reg;
            end else begin
                int_cnt_reg <= int_cnt_reg + 1'b1;
            end
        end
    end

    assign int_toggle = frame_reg & use_int & (shift_cnt_reg < 6'(GROUPS)) &
        (int_cnt_reg == acti_pkg::CNT_W'(acti_pkg::INT_HALF_CYC - 1));
    assign int_rise = int_toggle & ~int_clk_reg;
    assign int_fall = int_toggle & int_clk_reg;

    always_comb begin
        if (use_int) begin
            launch = int_fall | (ddr_enable & int_rise);
        end else if (ddr_enable) begin
            launch = sclk_rise | sclk_fall;
        end else if (output_protocol_select == acti_pkg::OUT_EARLY) begin
            launch = sclk_rise;
        end else begin
            launch = sclk_fall;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output shift register

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            frame_reg     <= 1'b0;
            zone2_reg     <= 1'b0;
            odr_reg       <= '0;
            shift_cnt_reg <= '0;
        end else if (cs_fall) begin
            frame_reg     <= 1'b1;
            zone2_reg     <= busy_reg;
            odr_reg       <= out_word_reg;
            shift_cnt_reg <= '0;
        end else if (cs_rise) begin
            frame_reg <= 1'b0;
        end else if (frame_reg && launch) begin
            odr_reg <= W'({odr_reg, {LANES{1'b0}}});
            if (shift_cnt_reg != '1) begin
                shift_cnt_reg <= shift_cnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input shift register, always on sclk capture edges

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            idr_reg      <= acti_pkg::NOP_COMMAND;
            sclk_cnt_reg <= '0;
            cmd_word     <= acti_pkg::NOP_COMMAND;
            cmd_valid    <= 1'b0;
        end else begin
            cmd_valid <= 1'b0;
            if (cs_fall) begin
                idr_reg      <= acti_pkg::NOP_COMMAND;
                sclk_cnt_reg <= '0;
            end else if (cs_rise && frame_reg) begin
                // short frames are dropped here, reads are not affected
                if (sclk_cnt_reg >= 6'(W)) begin
                    cmd_word  <= idr_reg;
                    cmd_valid <= 1'b1;
                end
            end else if (frame_reg && sclk_rise) begin
                idr_reg <= {idr_reg[W-2:0], pin_s2_reg[0]};
                if (sclk_cnt_reg != '1) begin
                    sclk_cnt_reg <= sclk_cnt_reg + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe; the echo is registered in the same cycle as the data shift

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            echo_reg <= 1'b0;
        end else begin
            echo_reg <= pin_s2_reg[1];
        end
    end

    // idle low in strobe mode so the host never sees a spurious edge
    assign link.ready_strobe_out = devclk ?
        (frame_reg & (use_int ? int_clk_reg : echo_reg)) : ~frame_reg;
    assign link.serial_out_lanes = odr_reg[W-1 -: LANES];
    assign link.sdo_oe           = frame_reg;
endmodule

// [hw/acti_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module acti_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input  logic             clock,
    input  logic             sys_rst,
    input  logic             in_valid,
    output logic             in_ready,
    input  logic [WIDTH-1:0] in_data,
    output logic             out_valid,
    input  logic             out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic [AW:0]      level;
    logic             push;
    logic             pop;

    assign level     = wr_ptr_reg - rd_ptr_reg;
    assign in_ready  = level < (AW + 1)'(DEPTH);
    assign out_valid = level != '0;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // pointers wrap at DEPTH; with a non-power-of-two depth the level overcounts and in_ready drops early
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg[AW-1:0] == AW'(DEPTH - 1)) ?
                    {~wr_ptr_reg[AW], {AW{1'b0}}} : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg[AW-1:0] == AW'(DEPTH - 1)) ?
                    {~rd_ptr_reg[AW], {AW{1'b0}}} : rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule

// [hw/acti_host_end.sv]
// host end: conversion pacing, zone-timed read frames, result fifo
`timescale 1ns/1ps
module acti_host_end #(
    parameter int LANES = 1,
    parameter int DEPTH = 4
) (
    input  logic                             clock,
    input  logic                             sys_rst,
    acti_link_if.host                        link,
    input  logic                             enable,
    input  logic                             zone_select,
    input  acti_pkg::acti_out_mode_type      output_protocol_select,
    input  logic                             ddr_enable,
    input  logic                             full_frame,
    input  logic [acti_pkg::WORD_BITS-1:0]   command_word,
    output logic [acti_pkg::READ_BITS-1:0]   result_data,
    output logic                             result_valid,
    input  logic                             result_ready
);
    localparam int R  = acti_pkg::READ_BITS;
    localparam int GB = ((R + LANES - 1) / LANES) * LANES;
    localparam int CW = acti_pkg::CNT_W;

    acti_pkg::acti_host_state_type state_reg;
    logic [CW-1:0]       cyc_reg;
    logic [CW-1:0]       cyc_next;
    logic                cst_reg;
    logic [1:0]          starts_reg;
    logic                read_done_reg;
    logic                quiet;
    logic                go;
    logic                finish;
    logic                fifo_ready;
    logic [LANES:0]      pin_s1_reg;
    logic [LANES:0]      pin_s2_reg;
    logic [LANES:0]      pin_d_reg;
    logic                cs_n_reg;
    logic                sclk_reg;
    logic [CW-1:0]       half_reg;
    logic                toggle;
    logic                h_rise;
    logic                h_fall;
    logic                capture;
    logic [LANES-1:0]    cap_data;
    logic [GB-1:0]       rx_reg;
    logic [5:0]          rx_cnt_reg;
    logic [5:0]          rise_cnt_reg;
    logic                rx_done;
    logic [acti_pkg::WORD_BITS-1:0] tx_reg;

    ////////////////////////////////////////////////////////////////////////
    // conversion pacing

    assign cyc_next = (cyc_reg == CW'(acti_pkg::CYCLE_CYC - 1)) ?
                      '0 : cyc_reg + 1'b1;

    always_ff @(posedge clock) begin
        if (sys_rst || !enable) begin
            cyc_reg    <= '0;
            cst_reg    <= 1'b0;
            starts_reg <= '0;
        end else begin
            cyc_reg <= cyc_next;
            cst_reg <= (cyc_next == '0) |
                       (cst_reg & (cyc_next < CW'(acti_pkg::APERTURE_CYC)));
            if (cyc_next == '0 && starts_reg != '1) begin
                starts_reg <= starts_reg + 1'b1;
            end
        end
    end

    // aperture after a start and acquisition before the next one
    assign quiet = enable & (cst_reg |
        (cyc_reg >= CW'(acti_pkg::CYCLE_CYC - acti_pkg::QT_ACQ_CYC)));

    // zone 1 waits for the result, zone 2 for the next start
    assign go = (state_reg == acti_pkg::H_IDLE) & enable & ~quiet &
        ~read_done_reg & fifo_ready &
        (zone_select ? (starts_reg == 2'h2 || starts_reg == 2'h3) :
         (starts_reg != '0 & (cyc_reg >= CW'(acti_pkg::CONV_CYC +
                                             acti_pkg::LINK_LAT_CYC))));

    ////////////////////////////////////////////////////////////////////////
    // frame control

    assign rx_done = rx_cnt_reg >= 6'(R);
    assign finish  = (state_reg == acti_pkg::H_FRAME) & rx_done & ~sclk_reg &
        ~quiet & (~full_frame | (rise_cnt_reg >= 6'(acti_pkg::WORD_BITS)));

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg     <= acti_pkg::H_IDLE;
            cs_n_reg      <= 1'b1;
            read_done_reg <= 1'b0;
        end else begin
            if (cyc_next == '0 || !enable) begin
                read_done_reg <= 1'b0;
            end
            case (state_reg)
                acti_pkg::H_IDLE: begin
                    if (go) begin
                        state_reg     <= acti_pkg::H_FRAME;
                        cs_n_reg      <= 1'b0;
                        read_done_reg <= 1'b1;
                    end
                end
                acti_pkg::H_FRAME: begin
                    if (finish) begin
                        state_reg <= acti_pkg::H_IDLE;
                        cs_n_reg  <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= acti_pkg::H_IDLE;
                    cs_n_reg  <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial clock divider, paused while quiet

    assign toggle = (state_reg == acti_pkg::H_FRAME) & ~quiet &
        (half_reg == CW'(acti_pkg::SCLK_HALF_CYC - 1)) &
        (sclk_reg | ~rx_done |
         (full_frame & (rise_cnt_reg < 6'(acti_pkg::WORD_BITS))));
    assign h_rise = toggle & ~sclk_reg;
    assign h_fall = toggle & sclk_reg;

    always_ff @(posedge clock) begin
        if (sys_rst || state_reg != acti_pkg::H_FRAME) begin
            half_reg <= '0;
            sclk_reg <= 1'b0;
        end else if (!quiet) begin
            if (toggle) begin
                half_reg <= '0;
                sclk_reg <= ~sclk_reg;
            end else if (half_reg != CW'(acti_pkg::SCLK_HALF_CYC - 1)) begin
                half_reg <= half_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive path

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_d_reg  <= '0;
        end else begin
            pin_s1_reg <= {link.ready_strobe_out, link.serial_out_lanes};
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg  <= pin_s2_reg;
        end
    end

    // strobe mode samples the data held before the strobe edge
    always_comb begin
        if (output_protocol_select == acti_pkg::OUT_DEVCLK) begin
            capture = (pin_s2_reg[LANES] & ~pin_d_reg[LANES]) |
                (ddr_enable & ~pin_s2_reg[LANES] & pin_d_reg[LANES]);
            cap_data = pin_d_reg[LANES-1:0];
        end else begin
            capture  = h_rise | (ddr_enable & h_fall);
            cap_data = pin_s2_reg[LANES-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || go) begin
            rx_reg       <= '0;
            rx_cnt_reg   <= '0;
            rise_cnt_reg <= '0;
        end else if (state_reg == acti_pkg::H_FRAME) begin
            if (capture && !rx_done) begin
                rx_reg     <= GB'({rx_reg, cap_data});
                rx_cnt_reg <= rx_cnt_reg + 6'(LANES);
            end
            if (h_rise && rise_cnt_reg != '1) begin
                rise_cnt_reg <= rise_cnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit path, changes on falling edges for rising-edge capture

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_reg <= acti_pkg::NOP_COMMAND;
        end else if (go) begin
            tx_reg <= command_word;
        end else if (h_fall) begin
            tx_reg <= {tx_reg[acti_pkg::WORD_BITS-2:0], 1'b0};
        end
    end

    // a full fifo stops new frames, so no result is ever pushed and lost
    acti_fifo #(
        .WIDTH (R),
        .DEPTH (DEPTH)
    ) result_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (finish),
        .in_ready  (fifo_ready),
        .in_data   (rx_reg[GB-1 -: R]),
        .out_valid (result_valid),
        .out_ready (result_ready),
        .out_data  (result_data)
    );

    assign link.conversion_start = cst_reg;
    assign link.cs_n             = cs_n_reg;
    assign link.sclk             = sclk_reg;
    assign link.sdi              = tx_reg[acti_pkg::WORD_BITS-1];
endmodule

// [hw/acti_link_if.sv]
// serial link between the converter end and the host controller end
`timescale 1ns/1ps
interface acti_link_if #(parameter int LANES = 1);
    logic             conversion_start;
    logic             cs_n;
    logic             sclk;
    logic             sdi;
    logic [LANES-1:0] serial_out_lanes;
    logic             sdo_oe;
    logic             ready_strobe_out;

    modport device (
        input  conversion_start,
        input  cs_n,
        input  sclk,
        input  sdi,
        output serial_out_lanes,
        output sdo_oe,
        output ready_strobe_out
    );
    modport host (
        output conversion_start,
        output cs_n,
        output sclk,
        output sdi,
        input  serial_out_lanes,
        input  sdo_oe,
        input  ready_strobe_out
    );
endinterface

// [hw/acti_pkg.sv]
// shared constants and types for the conversion / transfer interleave link
// How it works
// - internal clock launches data, serial clock still captures
// - result enters shift register at next select fall
// - host selects before next conversion finishes
// - host quiet around each conversion start
// - host reads in zone one or zone two
// - eighteen serial clocks fit the read window
// - frame may span zones, pausing in quiet
// - zone two strobe mode only echoes clock
// - standard mode launches opposite host capture edge
// - early mode launches half period sooner
// - device clock mode drives aligned strobe
// - lanes, double rate, zone two combine freely
// - host spaces starts one cycle time apart
// - select fall loads word, clears counter, input
// - short frame writes nothing, read data valid
// - optimal read takes eighteen top bits
package acti_pkg;
    localparam int WORD_BITS     = 22;
    localparam int READ_BITS     = 18;
    localparam int PAD_BITS      = 4;
    localparam int CNT_W         = 12;
    localparam int CLK_MHZ       = 100;
    localparam int T_CONV_NS     = 600;
    localparam int T_CYCLE_NS    = 5000;
    localparam int T_QT_ACQ_NS   = 200;
    localparam int T_APERTURE_NS = 100;
    localparam int T_SCLK_NS     = 160;
    localparam int T_INT_CLK_NS  = 80;
    localparam int LINK_LAT_CYC  = 4;

    function automatic int cyc_up(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CONV_CYC      = cyc_up(T_CONV_NS);
    localparam int CYCLE_CYC     = cyc_up(T_CYCLE_NS);
    localparam int QT_ACQ_CYC    = cyc_up(T_QT_ACQ_NS);
    localparam int APERTURE_CYC  = cyc_up(T_APERTURE_NS);
    localparam int SCLK_HALF_CYC = cyc_up(T_SCLK_NS / 2);
    localparam int INT_HALF_CYC  = cyc_up(T_INT_CLK_NS / 2);

    typedef enum logic [1:0] {
        OUT_STANDARD = 2'b00,
        OUT_EARLY    = 2'b01,
        OUT_RESERVED = 2'b10,
        OUT_DEVCLK   = 2'b11
    } acti_out_mode_type;

    localparam logic [1:0] STROBE_ECHO = 2'h0;
    localparam logic [WORD_BITS-1:0] NOP_COMMAND = 22'h00_0000;

    typedef enum logic [0:0] {
        H_IDLE  = 1'b0,
        H_FRAME = 1'b1
    } acti_host_state_type;
endpackage

// [tb/acti_link_props.sv]
// checker of the link timing between the two ends
`timescale 1ns/1ps
module acti_link_props (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic conversion_start,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdo_oe,
    input wire logic ready_strobe_out
);
    logic [9:0] gap_reg;
    logic [6:0] strb_reg;
    logic [7:0] calm_reg;
    logic [6:0] edge_reg;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // all-ones marks no start seen yet, so the first start is not judged
    always_ff @(posedge clock) begin
        if (sys_rst) gap_reg <= 10'h3ff;
        else if ($rose(conversion_start)) gap_reg <= 10'h000;
        else if (gap_reg != 10'h3ff) gap_reg <= gap_reg + 10'h001;
    end
    always_ff @(posedge clock) begin
        if (sys_rst) calm_reg <= 8'hff;
        else if ($changed(sclk)) calm_reg <= 8'h00;
        else if (calm_reg != 8'hff) calm_reg <= calm_reg + 8'h01;
    end
    // both sclk edges count, so double rate frames are judged alike
    always_ff @(posedge clock) begin
        if (sys_rst || $fell(cs_n)) edge_reg <= 7'h00;
        else if (!cs_n && $changed(sclk)) edge_reg <= edge_reg + 7'h01;
    end
    // internal clock reads are timed by the strobe, not by sclk
    always_ff @(posedge clock) begin
        if (sys_rst || $fell(cs_n)) strb_reg <= 7'h00;
        else if (!cs_n && $changed(ready_strobe_out))
            strb_reg <= strb_reg + 7'h01;
    end
    sequence quiet_s;
        ($stable(sclk) && $stable(cs_n))[*8];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    AST_OE_ON: assert property ($fell(cs_n) |-> ##[3:4] sdo_oe)
        else $error("data lanes not taken after select fall");
    AST_OE_OFF: assert property ($rose(cs_n) |-> ##[3:4] !sdo_oe)
        else $error("data lanes still driven after select rise");
    AST_START_WIDTH: assert property (
        $rose(conversion_start) |-> conversion_start[*8])
        else $error("start pulse too short");
    AST_QUIET_APER: assert property ($rose(conversion_start) |-> quiet_s)
        else $error("link toggled in aperture");
    AST_QUIET_ACQ: assert property (
        $rose(conversion_start) |-> calm_reg >= 8'(acti_pkg::QT_ACQ_CYC - 2))
        else $error("sclk toggled before start");
    AST_SPACING: assert property (
        $rose(conversion_start) && gap_reg != 10'h3ff
        |-> gap_reg == 10'(acti_pkg::CYCLE_CYC - 1))
        else $error("start spacing wrong");
    AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
        else $error("sclk high outside frame");
    AST_READ_LEN: assert property (
        $rose(cs_n) |-> edge_reg >= 7'(acti_pkg::READ_BITS) ||
            strb_reg >= 7'(acti_pkg::READ_BITS))
        else $error("frame ended before result read");
endmodule

// [tb/adc_conversion_transfer_interleave_tb.sv]
// self-checking bench joining both link ends
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    num_errors++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module adc_conversion_transfer_interleave_tb;
    logic                        clock = 0, sys_rst = 1, enable = 0;
    logic                        zone_select = 0, ddr_enable = 0;
    logic                        full_frame = 0, result_ready = 0;
    logic [1:0]                  strobe_source_select = 2'h0;
    acti_pkg::acti_out_mode_type mode = acti_pkg::OUT_STANDARD;
    logic [17:0]                 sample_data = 18'h0_0000, result_data;
    logic [21:0]                 command_word = 22'h00_0000, cmd_word;
    logic [21:0]                 cap = 22'h00_0000;
    logic                        result_valid, cmd_valid;
    int                          num_errors = 0, checks_done = 0;
    int                          cmd_seen = 0, n = 0, k;
    acti_link_if #(.LANES(1)) link ();
    acti_device_end #(.LANES(1)) acti_device_end_inst (.clock(clock),
        .sys_rst(sys_rst), .link(link), .sample_data(sample_data),
        .output_protocol_select(mode), .ddr_enable(ddr_enable),
        .strobe_source_select(strobe_source_select), .sample_taken(),
        .cmd_word(cmd_word), .cmd_valid(cmd_valid));
    acti_host_end #(.LANES(1), .DEPTH(4)) acti_host_end_inst (.clock(clock),
        .sys_rst(sys_rst), .link(link), .enable(enable),
        .zone_select(zone_select), .output_protocol_select(mode),
        .ddr_enable(ddr_enable), .full_frame(full_frame),
        .command_word(command_word), .result_data(result_data),
        .result_valid(result_valid), .result_ready(result_ready));
    acti_link_props acti_link_props_inst (.clock(clock), .sys_rst(sys_rst),
        .conversion_start(link.conversion_start), .cs_n(link.cs_n),
        .sclk(link.sclk), .sdo_oe(link.sdo_oe),
        .ready_strobe_out(link.ready_strobe_out));
    initial forever #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock) if (cmd_valid === 1'b1) begin
        cmd_seen++;
        `CHK("cmd_word", command_word, cmd_word)
    end
    // bits seen on the wire at host capture, msb first
    always @(negedge link.cs_n) begin cap = 22'h00_0000; n = 0; end
    always @(posedge link.sclk) if (!link.cs_n) begin
        cap = {cap[20:0], link.serial_out_lanes[0]};
        n++;
    end
    always @(posedge link.cs_n) if (!sys_rst && !ddr_enable && n > 0 &&
        n <= 22 && mode != acti_pkg::OUT_DEVCLK)
        `CHK("wire", 22'({sample_data, 4'h0} >> (22 - n)), cap)
    ////////////////////////////////////////////////////////////////////////
    task automatic pop(input logic [17:0] s);
        int w = 0;
        while (result_valid !== 1'b1 && w < 3000) begin
            @(posedge clock);
            #1 w++;
        end
        `CHK("valid", 1'b1, result_valid)
        `CHK("result", s, result_data)
        result_ready = 1;
        @(posedge clock);
        #1 result_ready = 0;
    endtask
    // c = mode, zone, ddr, full frame, strobe source
    task automatic run_cfg(input logic [6:0] c, input logic [17:0] s);
        @(posedge clock);
        #1 sys_rst = 1;
        mode = acti_pkg::acti_out_mode_type'(c[6:5]);
        {zone_select, ddr_enable, full_frame} = c[4:2];
        strobe_source_select = c[1:0];
        sample_data = s;
        command_word = {s, 4'h5};
        repeat (8) @(posedge clock);
        #1 sys_rst = 0;
        enable = 1;
        cmd_seen = 0;
        pop(s);
        pop(s);
        `CHK("cmd_seen", full_frame, 1'(cmd_seen != 0))
    endtask
    task end_sim;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        end_sim();
    end
    initial begin
        run_cfg(7'h04, 18'h2_0001);
        run_cfg(7'h20, 18'h3_ffff);
        run_cfg(7'h18, 18'h1_5555);
        run_cfg(7'h64, 18'h2_aaaa);
        run_cfg(7'h69, 18'h0_0001);
        run_cfg(7'h72, 18'h3_c3c3);
        run_cfg(7'h34, 18'h0_ff00);
        // stall the reader so the result fifo fills and refuses
        repeat (3000) @(posedge clock);
        #1 k = 0;
        `CHK("cs_idle", 1'b1, link.cs_n)
        result_ready = 1;
        repeat (8) begin
            if (result_valid === 1'b1) k++;
            @(posedge clock);
            #1;
        end
        `CHK("fifo_fill", 4, k)
        end_sim();
    end
endmodule
